//--- rtl/bac_cfg.svh
// constants for the burst address counter with counter mask
`ifndef BAC_CFG_SVH
`define BAC_CFG_SVH
`define BAC_AW            16
`define BAC_CNT_RST       16'h0000
`define BAC_MASK_RST      16'hFFFF
`define BAC_OFS_CTRL      4'h0
`define BAC_OFS_COUNT     4'h4
`define BAC_OFS_MASK      4'h8
`define BAC_OFS_WRAPS     4'hC
`define BAC_CTRL_CLR_BIT  0
`define BAC_RESP_OKAY     2'h0
`define BAC_RESP_DECERR   2'h3
`endif

//--- rtl/bac_counter.sv
// burst address counter with counter mask and AXI4-Lite status port
// Notes on behaviour
// - wrap flag low one cycle on unmasked rollover
// - mask one bit lets counter bit step
// - blocked bits never change on increment
// - field at mask value wraps to zero
// - all-ones mask covers full 64K space
// - load strobes capture address lines
// - mask load beats counter load
// - mask bit0 zero steps by two
// - mask bit0 one steps by one
// - strobes sampled on rising clock edge
// - fixed priority from reset down to hold
// - master clear: counter zero, mask ones
// - counter clear leaves mask untouched
// - increment strobe low steps each edge
// - readback drives counter or mask on address
// - readback value appears two edges later
// - readback with chip enabled floats data
// - all strobes high holds counter
// - chip enables do not gate operations
// - master clear sets wrap flag high
// - mask readout alone presents mask
`timescale 1ns/10ps
module bac_counter
	import bac_pkg::*;
(
	// clock and resets
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        master_clear_n,
	// port control strobes
	input  wire bac_ctl_s    ctl,
	input  wire logic        chip_enable_low_active,
	input  wire logic        chip_enable_high_active,
	// address lines
	input  wire bac_word_t   addr_in,
	output logic [15:0]      addr_out,
	output logic             addr_oe,
	output logic             data_hiz,
	output logic             wrap_flag_n,
	// axi4-lite slave
	input  wire logic [3:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [3:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	bac_state_s st;
	bac_state_s next_st;

	localparam bac_state_s ST_RST = '{
		counter: `BAC_CNT_RST, mask: `BAC_MASK_RST, wrap_flag_n: 1'b1,
		rb_phase: BAC_RB_IDLE, rb_mask_sel: 1'b0, addr_out: 16'h0000,
		addr_oe: 1'b0, data_hiz: 1'b0, wraps: 16'h0000, sw_clear: 1'b0,
		aw_got: 1'b0, w_got: 1'b0, awaddr: 4'h0, wdata: 32'h00000000,
		bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rdata: 32'h00000000,
		rresp: 2'h0};

	// masked step: blocked bits forced to one so the carry skips them
	function automatic bac_word_t step_value(bac_word_t c, bac_word_t m);
		bac_word_t s;
		s = (c | ~m) + 16'h0001;
		return (c & ~m) | (s & m);
	endfunction : step_value

	function automatic logic at_wrap(bac_word_t c, bac_word_t m);
		return (c & m) == m;
	endfunction : at_wrap

	function automatic logic addr_ok(logic [3:0] a);
		return a == `BAC_OFS_CTRL || a == `BAC_OFS_COUNT ||
			a == `BAC_OFS_MASK || a == `BAC_OFS_WRAPS;
	endfunction : addr_ok

	logic chip_on;
	logic do_clear;
	logic do_mask;
	logic do_load;
	logic do_step;
	logic do_rb;
	logic aw_hs;
	logic w_hs;

	assign chip_on = !chip_enable_low_active && chip_enable_high_active;
	// exclusive priority chain
	assign do_clear = !ctl.counter_clear_n || st.sw_clear;
	assign do_mask  = !do_clear && !ctl.mask_load_n;
	assign do_load  = !do_clear && ctl.mask_load_n && !ctl.counter_load_n;
	assign do_step  = !do_clear && ctl.mask_load_n && ctl.counter_load_n &&
		!ctl.count_step_n;
	assign do_rb    = !do_clear && ctl.mask_load_n && ctl.counter_load_n &&
		ctl.count_step_n &&
		(!ctl.counter_readout_n || !ctl.mask_readout_n);

	assign s_awready = !st.aw_got && !st.bvalid;
	assign s_wready  = !st.w_got && !st.bvalid;
	assign s_arready = !st.rvalid;
	assign aw_hs = s_awvalid && s_awready;
	assign w_hs  = s_wvalid && s_wready;

	always_comb begin
		next_st = st;
		next_st.wrap_flag_n = 1'b1;
		next_st.sw_clear = 1'b0;
		// counter and mask, chip enables not consulted
		if (do_clear) begin
			next_st.counter = `BAC_CNT_RST;
		end else if (do_mask) begin
			next_st.mask = addr_in;
		end else if (do_load) begin
			next_st.counter = addr_in;
		end else if (do_step) begin
			next_st.counter = step_value(st.counter, st.mask);
			if (at_wrap(st.counter, st.mask)) begin
				next_st.wrap_flag_n = 1'b0;
				next_st.wraps = st.wraps + 16'h0001;
			end
		end
		// otherwise hold
		// readback: one idle cycle, then drive
		case (st.rb_phase)
			BAC_RB_IDLE: begin
				next_st.addr_oe = 1'b0;
				if (do_rb) begin
					next_st.rb_phase = BAC_RB_WAIT;
					next_st.rb_mask_sel = ctl.counter_readout_n;
				end
			end
			BAC_RB_WAIT, BAC_RB_DRIVE: begin
				next_st.addr_out = st.rb_mask_sel ? st.mask : st.counter;
				next_st.addr_oe = 1'b1;
				next_st.rb_phase = BAC_RB_DRIVE;
				if (do_rb) begin
					next_st.rb_mask_sel = ctl.counter_readout_n;
				end else if (st.rb_phase == BAC_RB_DRIVE) begin
					next_st.rb_phase = BAC_RB_IDLE;
					next_st.addr_oe = 1'b0;
				end
			end
			default: begin
				next_st.rb_phase = BAC_RB_IDLE;
				next_st.addr_oe = 1'b0;
			end
		endcase
		next_st.data_hiz = do_rb && chip_on;
		// axi write
		if (aw_hs) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_awaddr;
		end
		if (w_hs) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_wstrb[0] ? s_wdata : 32'h00000000;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = addr_ok(st.awaddr) ? `BAC_RESP_OKAY : `BAC_RESP_DECERR;
			if (st.awaddr == `BAC_OFS_CTRL) begin
				next_st.sw_clear = st.wdata[`BAC_CTRL_CLR_BIT];
			end
		end else if (st.bvalid && s_bready) begin
			next_st.bvalid = 1'b0;
		end
		// axi read
		if (s_arvalid && s_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = addr_ok(s_araddr) ? `BAC_RESP_OKAY : `BAC_RESP_DECERR;
			case (s_araddr)
				`BAC_OFS_COUNT: next_st.rdata = {16'h0000, st.counter};
				`BAC_OFS_MASK:  next_st.rdata = {16'h0000, st.mask};
				`BAC_OFS_WRAPS: next_st.rdata = {16'h0000, st.wraps};
				default:        next_st.rdata = 32'h00000000;
			endcase
		end else if (st.rvalid && s_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// master clear acts at once, bus reset on the clock
	always_ff @(posedge aclk or negedge master_clear_n) begin
		if (!master_clear_n) begin
			st <= ST_RST;
		end else if (!aresetn) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	assign addr_out    = st.addr_out;
	assign addr_oe     = st.addr_oe;
	assign data_hiz    = st.data_hiz;
	assign wrap_flag_n = st.wrap_flag_n;
	assign s_bresp     = st.bresp;
	assign s_bvalid    = st.bvalid;
	assign s_rdata     = st.rdata;
	assign s_rresp     = st.rresp;
	assign s_rvalid    = st.rvalid;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !master_clear_n);

	property p_wrap_pulse;
		do_step && at_wrap(st.counter, st.mask) |=> !wrap_flag_n ##1 wrap_flag_n;
	endproperty
	a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse wrong");

	property p_blocked;
		do_step |=> ((st.counter & ~st.mask) == ($past(st.counter) & ~$past(st.mask)));
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked bit moved");

	property p_field_wrap;
		do_step && at_wrap(st.counter, st.mask) |=> (st.counter & st.mask) == 16'h0000;
	endproperty
	a_field_wrap: assert property (p_field_wrap) else $error("field did not wrap");

	property p_by_one;
		do_step && st.mask == 16'hFFFF |=> st.counter == $past(st.counter) + 16'h0001;
	endproperty
	a_by_one: assert property (p_by_one) else $error("step by one failed");

	property p_by_two;
		do_step && st.mask == 16'hFFFE |=> st.counter == $past(st.counter) + 16'h0002;
	endproperty
	a_by_two: assert property (p_by_two) else $error("step by two failed");

	property p_mask_wins;
		!ctl.mask_load_n && !ctl.counter_load_n && ctl.counter_clear_n && !st.sw_clear
		|=> st.mask == $past(addr_in) && st.counter == $past(st.counter);
	endproperty
	a_mask_wins: assert property (p_mask_wins) else $error("load priority wrong");

	property p_clear_keeps_mask;
		!ctl.counter_clear_n |=> st.counter == 16'h0000 && $stable(st.mask);
	endproperty
	a_clear_keeps_mask: assert property (p_clear_keeps_mask) else $error("clear wrong");

	property p_hold;
		ctl == 6'h3F && !st.sw_clear |=> $stable(st.counter) && $stable(st.mask);
	endproperty
	a_hold: assert property (p_hold) else $error("hold changed state");

	property p_rb_latency;
		st.rb_phase == BAC_RB_IDLE && do_rb && !ctl.counter_readout_n
		|=> !addr_oe ##1 addr_oe && addr_out == $past(st.counter);
	endproperty
	a_rb_latency: assert property (p_rb_latency) else $error("readback timing wrong");

	property p_hiz;
		do_rb && chip_on |=> data_hiz;
	endproperty
	a_hiz: assert property (p_hiz) else $error("data not floated");

	property p_load;
		do_load |=> st.counter == $past(addr_in);
	endproperty
	a_load: assert property (p_load) else $error("counter load wrong");

	property p_mask_load;
		do_mask |=> st.mask == $past(addr_in);
	endproperty
	a_mask_load: assert property (p_mask_load) else $error("mask load wrong");

	property p_load_keeps_mask;
		do_load |=> $stable(st.mask);
	endproperty
	a_load_keeps_mask: assert property (p_load_keeps_mask) else $error("mask moved");

	property p_full_wrap;
		do_step && st.mask == 16'hFFFF && st.counter == 16'hFFFF
		|=> st.counter == 16'h0000 && !wrap_flag_n;
	endproperty
	a_full_wrap: assert property (p_full_wrap) else $error("full wrap wrong");

	property p_no_wrap;
		!do_step |=> wrap_flag_n;
	endproperty
	a_no_wrap: assert property (p_no_wrap) else $error("wrap without step");

	property p_wrap_cause;
		do_step && !at_wrap(st.counter, st.mask) |=> wrap_flag_n;
	endproperty
	a_wrap_cause: assert property (p_wrap_cause) else $error("false wrap");

	property p_step_keeps_mask;
		do_step |=> $stable(st.mask);
	endproperty
	a_step_keeps_mask: assert property (p_step_keeps_mask) else $error("mask stepped");

	property p_bit0_held;
		do_step && !st.mask[0] |=> st.counter[0] == $past(st.counter[0]);
	endproperty
	a_bit0_held: assert property (p_bit0_held) else $error("bit0 moved");

	property p_rb_keeps;
		do_rb |=> $stable(st.counter) && $stable(st.mask);
	endproperty
	a_rb_keeps: assert property (p_rb_keeps) else $error("readback changed state");

	property p_mask_rb;
		st.rb_phase == BAC_RB_IDLE && do_rb && ctl.counter_readout_n
		|=> !addr_oe ##1 addr_oe && addr_out == $past(st.mask);
	endproperty
	a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");

	property p_oe_idle;
		st.rb_phase == BAC_RB_IDLE |-> !addr_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("address driven idle");

	property p_hiz_off;
		!(do_rb && chip_on) |=> !data_hiz;
	endproperty
	a_hiz_off: assert property (p_hiz_off) else $error("data floated");

	property p_sw_clear;
		st.sw_clear |=> st.counter == 16'h0000 && $stable(st.mask);
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("soft clear wrong");

	property p_clear_no_wrap;
		do_clear |=> wrap_flag_n;
	endproperty
	a_clear_no_wrap: assert property (p_clear_no_wrap) else $error("wrap on clear");

	property p_bvalid_hold;
		s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");

	property p_rvalid_hold;
		s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped");

	property p_write_busy;
		s_bvalid |-> !s_awready && !s_wready;
	endproperty
	a_write_busy: assert property (p_write_busy) else $error("write ready early");

	property p_read_busy;
		s_rvalid |-> !s_arready;
	endproperty
	a_read_busy: assert property (p_read_busy) else $error("read ready early");

	c_rb_count: cover property (addr_oe && !st.rb_mask_sel);
	c_hiz: cover property (data_hiz);
	c_wrap: cover property (!wrap_flag_n);
	c_rb_mask: cover property (addr_oe && st.rb_mask_sel);
	c_by_two: cover property (do_step && !st.mask[0]);
endmodule : bac_counter

//--- rtl/bac_pkg.sv
// types for the burst address counter with counter mask
`include "bac_cfg.svh"
package bac_pkg;
	typedef logic [`BAC_AW-1:0] bac_word_t;
	typedef enum logic [1:0] {
		BAC_RB_IDLE  = 2'b00,
		BAC_RB_WAIT  = 2'b01,
		BAC_RB_DRIVE = 2'b10
	} bac_rb_e;
	typedef struct packed {
		logic counter_clear_n;
		logic mask_load_n;
		logic counter_load_n;
		logic count_step_n;
		logic counter_readout_n;
		logic mask_readout_n;
	} bac_ctl_s;
	typedef struct packed {
		bac_word_t   counter;
		bac_word_t   mask;
		logic        wrap_flag_n;
		bac_rb_e     rb_phase;
		logic        rb_mask_sel;
		bac_word_t   addr_out;
		logic        addr_oe;
		logic        data_hiz;
		logic [15:0] wraps;
		logic        sw_clear;
		logic        aw_got;
		logic        w_got;
		logic [3:0]  awaddr;
		logic [31:0] wdata;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} bac_state_s;
endpackage : bac_pkg

//--- test/bac_host.sv
// host logic model driving one port's address lines
`timescale 1ns/10ps
module bac_host
	import bac_pkg::*;
(
	// from bench
	input  wire logic        aclk,
	input  wire logic        drv,
	input  wire bac_word_t   val,
	// device side
	input  wire logic [15:0] addr_out,
	input  wire logic        addr_oe,
	output bac_word_t        addr_in
);
	bac_word_t last = '0;
	always_ff @(posedge aclk) begin
		if (drv && !addr_oe)
			last <= val;
	end
	// released lines show the inverse of the last driven value
	assign addr_in = addr_oe ? addr_out : drv ? val : ~last;
endmodule : bac_host

//--- test/test_burst_address_counter_mask.sv
// self-checking bench for the burst address counter
`timescale 1ns/10ps
module test_burst_address_counter_mask
	import bac_pkg::*;
;
	logic        aclk = 0, aresetn = 0, mcn = 1, ce0 = 1, ce1 = 0, hd = 0;
	logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, en = 0;
	logic        oe, hiz, wrn, awr, wr, bv, arr, rv, exp_q = 1, exp_n = 1;
	bac_ctl_s    ctl = '1;
	bac_word_t   hv = '0, ain, cnt = '0, msk = 16'hFFFF;
	logic [15:0] aout;
	logic [3:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rd;
	logic [1:0]  bresp, rresp;
	int          failures = 0, total_checks = 0, seed = 82732, wraps = 0;
	always #4 aclk = ~aclk;
	bac_host host (.aclk(aclk), .drv(hd), .val(hv), .addr_out(aout),
		.addr_oe(oe), .addr_in(ain));
	bac_counter DUT (.aclk(aclk), .aresetn(aresetn), .master_clear_n(mcn),
		.ctl(ctl), .chip_enable_low_active(ce0),
		.chip_enable_high_active(ce1), .addr_in(ain), .addr_out(aout),
		.addr_oe(oe), .data_hiz(hiz), .wrap_flag_n(wrn), .s_awaddr(awa),
		.s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hF),
		.s_wvalid(wv), .s_wready(wr), .s_bresp(bresp), .s_bvalid(bv),
		.s_bready(br), .s_araddr(ara), .s_arvalid(arv), .s_arready(arr),
		.s_rdata(rd), .s_rresp(rresp), .s_rvalid(rv), .s_rready(rr));
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task end_of_test;
		if (failures == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	always @(negedge aclk) if (en) begin
		chk(wrn, exp_q);
		exp_q = exp_n;
		exp_n = 1;
	end
	// drive one op per cycle and advance the model by priority
	task automatic op(input bac_ctl_s c, input bac_word_t a, input int n);
		logic cy;
		repeat (n) begin
			@(posedge aclk);
			ctl <= c;
			hv <= a;
			hd <= !(c.mask_load_n && c.counter_load_n);
			if (!c.counter_clear_n)
				cnt = '0;
			else if (!c.mask_load_n)
				msk = a;
			else if (!c.counter_load_n)
				cnt = a;
			else if (!c.count_step_n) begin
				cy = 1;
				for (int k = 0; k < 16; k++) if (msk[k] && cy) begin
					cy = cnt[k];
					cnt[k] = !cnt[k];
				end
				exp_n = !cy;
				wraps += cy;
			end
		end
	endtask : op
	task automatic rbk(input bac_ctl_s c, input bac_word_t e);
		logic on;
		on = 1'($random(seed));
		ce0 <= !on;
		ce1 <= on;
		op(c, '0, 2);
		@(negedge aclk);
		chk(oe, 0);
		op('1, '0, 1);
		@(negedge aclk);
		chk({oe, hiz, aout}, {1'b1, on, e});
	endtask : rbk
	task automatic axw(input logic [3:0] a, input int d);
		logic [2:0] h;
		@(posedge aclk);
		{awa, wd, awv, wv, br} <= {a, d, 3'b111};
		repeat (20) begin
			@(negedge aclk);
			h = {awr & awv, wr & wv, bv};
			if (h[0]) chk(bresp, 0);
			@(posedge aclk);
			if (h[2]) awv <= 0;
			if (h[1]) wv <= 0;
			if (h[0]) break;
		end
		if (!h[0]) failures++;
		br <= 0;
	endtask : axw
	task automatic axr(input logic [3:0] a, input int e, input logic [1:0] r);
		logic [1:0] h;
		@(posedge aclk);
		{ara, arv, rr} <= {a, 2'b11};
		repeat (20) begin
			@(negedge aclk);
			h = {arr & arv, rv};
			if (h[0]) chk({rresp, rd}, {r, e});
			@(posedge aclk);
			if (h[1]) arv <= 0;
			if (h[0]) break;
		end
		if (!h[0]) failures++;
		rr <= 0;
	endtask : axr
	initial begin
		#100000;
		failures++;
		end_of_test;
	end
	initial begin
		logic [31:0] r;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		en = 1;
		axr(4'h4, 0, 0);
		axr(4'h8, 'hFFFF, 0);
		axr(4'h2, 0, 3);
		op(6'b100111, 'h003F, 1);
		rbk(6'b111101, 'h0000);
		rbk(6'b111110, 'h003F);
		op(6'b110111, 'h1238, 1);
		op(6'b111011, '0, 12);
		rbk(6'b111100, cnt);
		// odd-only walk, one half of an even/odd port pair
		op(6'b101111, 'h003E, 1);
		op(6'b110111, 'h0005, 1);
		op(6'b111011, '0, 40);
		rbk(6'b111101, cnt);
		op(6'b101111, 'hFFFF, 1);
		op(6'b110111, 'hFFFE, 1);
		op(6'b111011, '0, 3);
		rbk(6'b111101, cnt);
		op(6'b001111, 'h00F0, 1);
		rbk(6'b111110, msk);
		repeat (300) begin
			r = $random(seed);
			op({r[3:0] != 0, r[5:4] != 0, r[7:6] != 0, r[8], 2'b11},
				r[31:16], 1);
			ce0 <= r[9];
			ce1 <= r[10];
		end
		op('1, '0, 2);
		axr(4'h4, cnt, 0);
		axr(4'h8, msk, 0);
		axr(4'hC, wraps, 0);
		axw(4'h4, 'h55);
		axw(4'h0, 1);
		cnt = '0;
		axr(4'h4, 0, 0);
		axr(4'h8, msk, 0);
		op(6'b110111, 'h0123, 1);
		op(6'b111101, '0, 4);
		@(negedge aclk);
		mcn = 0;
		#1;
		chk({oe, wrn}, 2'b01);
		@(posedge aclk);
		mcn <= 1;
		cnt = '0;
		msk = 16'hFFFF;
		op('1, '0, 3);
		axr(4'h4, 0, 0);
		axr(4'h8, 'hFFFF, 0);
		end_of_test;
	end
endmodule : test_burst_address_counter_mask
